// file: src/mesf_pkg.sv
// Constants and types shared by the meter event status flag block
package mesf_pkg;

  // ----------------------------------------
  // Register word indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [15:0] STATUS_IDX = 16'he503;
  localparam logic [15:0] MASK_IDX = 16'he600;
  localparam logic [15:0] CTRL_IDX = 16'he601;
  localparam logic [15:0] IDLE_PH_IDX = 16'he602;
  localparam logic [15:0] PH_EVT_IDX = 16'he603;
  localparam logic [15:0] THRESH_IDX = 16'he604;

  // ----------------------------------------
  // Status and control bit positions
  // ----------------------------------------
  localparam int TOT_IDLE_BIT = 0;
  localparam int FUND_IDLE_BIT = 1;
  localparam int APP_IDLE_BIT = 2;
  localparam int VOLT_TIMEOUT_LSB = 3;
  localparam int CURR_TIMEOUT_LSB = 6;
  localparam int VOLT_SEEN_LSB = 9;
  localparam int CURR_SEEN_LSB = 12;
  localparam int RESET_DONE_BIT = 15;
  localparam int SAG_BIT = 16;
  localparam int HIGH_CURR_BIT = 17;
  localparam int HIGH_VOLT_BIT = 18;
  localparam int ORDER_ERR_BIT = 19;
  localparam int NEUTRAL_BIT = 20;
  localparam int CURR_PEAK_BIT = 23;
  localparam int VOLT_PEAK_BIT = 24;
  localparam int CKSUM_BIT = 25;
  localparam int CTRL_SOFTWARE_RESET_COMMAND_BIT = 0;

  // ----------------------------------------
  // Phase field positions
  // ----------------------------------------
  localparam int TOT_PH_LSB = 0;
  localparam int FUND_PH_LSB = 3;
  localparam int APP_PH_LSB = 6;
  localparam int HIGH_CURR_PH_LSB = 3;
  localparam int HIGH_VOLT_PH_LSB = 9;
  localparam int SAG_PH_LSB = 12;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [31:0] STATUS_RESET = 32'h0020_8000;
  localparam logic [31:0] RSVD_ONE = 32'h0020_0000;
  localparam logic [31:0] FLAG_MASK = 32'h039f_ffff;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [23:0] THRESH_RESET = 24'h00_0000;
  localparam logic [8:0] PHASE_RESET = 9'h000;
  localparam logic [14:0] PH_EVT_RESET = 15'h0000;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'h0,
    PWR_REDUCED_ONE = 2'h1,
    PWR_REDUCED_TWO = 2'h2,
    PWR_SLEEP = 2'h3
  } mesf_pwr_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SETTLE = 2'b10
  } mesf_state_t;

  // Byte enables to a 32-bit bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

endpackage : mesf_pkg

// file: src/mesf_order_chk.sv
// Phase rotation checker on rising voltage crossings
module mesf_order_chk (
  input wire logic clk, // Core clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic [2:0] volt_rise, // Rising crossing pulses, C B A
  output logic order_err // One-cycle error pulse
);

  typedef struct packed {
    logic armed;
    logic err;
  } mesf_order_st_t;

  mesf_order_st_t s_q;
  mesf_order_st_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.err = 1'b0;
    if (s_q.armed && volt_rise[1])
    begin
      s_d.armed = 1'b0;
    end
    else if (s_q.armed && volt_rise[2])
    begin
      s_d.armed = 1'b0;
      s_d.err = 1'b1; // [R13]
    end
    if (volt_rise[0])
    begin
      s_d.armed = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign order_err = s_q.err;

endmodule : mesf_order_chk

// file: src/mesf_neutral_cmp.sv
// Neutral current imbalance comparator
module mesf_neutral_cmp (
  input wire logic clk, // Core clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic enable, // Neutral measurement present
  input wire logic signed [23:0] summed_phase_current, // Sum of phase currents
  input wire logic signed [23:0] neutral_current_sample, // Measured neutral
  input wire logic [23:0] neutral_imbalance_threshold, // Limit
  output logic over // Registered imbalance level
);

  typedef struct packed {
    logic over;
  } mesf_cmp_st_t;

  mesf_cmp_st_t s_q;
  mesf_cmp_st_t s_d;
  logic signed [24:0] diff;
  logic [24:0] mag;

  always_comb
  begin
    diff = 25'(summed_phase_current) - 25'(neutral_current_sample);
    mag = diff[24] ? 25'(-diff) : 25'(diff);
    s_d.over = enable && (mag > {1'b0, neutral_imbalance_threshold}); // [R14]
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign over = s_q.over;

endmodule : mesf_neutral_cmp

// file: src/mesf_status_top.sv
// Event status flag register with Avalon-MM access and interrupt line
//
// Chosen here: register access over Avalon-MM.

// Behaviour
// R01: Bit 0 sets on total-power idle; phase latched in idle phase bits 2:0.
// R02: Bit 1 sets on fundamental idle; phase in bits 5:3; zero without fundamental.
// R03: Bit 2 sets on apparent-power idle; phase in idle phase bits 8:6.
// R04: Bits 3 to 5 set on missing voltage crossing, phases A, B, C.
// R05: Bits 6 to 8 set on missing current crossing, phases A, B, C.
// R06: Bits 9 to 11 set on detected voltage crossing, phases A, B, C.
// R07: Bits 12 to 14 set on detected current crossing, phases A, B, C.
// R08: Bit 15 resets to 1; sets after any reset or return to normal power.
// R09: Reset-complete flag pulls the interrupt low and cannot be masked.
// R10: Bit 16 sets on sag; phases in phase event bits 14:12.
// R11: Bit 17 sets on overcurrent; phases in phase event bits 5:3.
// R12: Bit 18 sets on overvoltage; phases in phase event bits 11:9.
// R13: Bit 19 sets when A rising is followed by C, not B.
// R14: Bit 20 sets on neutral imbalance above threshold; zero without neutral.
// R15: Bit 21 reads 1; bits 22 and 31 to 26 read 0.
// R16: Bit 23 sets when current peak period ends.
// R17: Bit 24 sets when voltage peak period ends.
// R18: Bit 25 sets whenever the checksum value changes.
// R19: Flags stay set until host writes 1; writing 0 leaves them.
// R20: Interrupt low while any enabled flag or reset-complete is set.
module mesf_status_top #(
  parameter bit HAS_FUNDAMENTAL = 1'b1, // Fundamental metering present
  parameter bit HAS_NEUTRAL = 1'b1 // Neutral measurement present
) (
  input wire logic clk, // 40 MHz core clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [15:0] avs_address, // Word index
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic total_power_idle_flag, // Total idle event pulse
  input wire logic [2:0] total_idle_phase_field, // Phases for it
  input wire logic fundamental_power_idle_flag, // Fundamental idle pulse
  input wire logic [2:0] fundamental_idle_phase_field, // Phases for it
  input wire logic apparent_power_idle_flag, // Apparent idle pulse
  input wire logic [2:0] apparent_idle_phase_field, // Phases for it
  input wire logic [2:0] volt_crossing_timeout, // Missing crossing, C B A
  input wire logic [2:0] curr_crossing_timeout, // Missing crossing, C B A
  input wire logic [2:0] volt_crossing_seen, // Crossing seen, C B A
  input wire logic [2:0] curr_crossing_seen, // Crossing seen, C B A
  input wire logic [2:0] volt_rising_crossing, // Rising crossing, C B A
  input wire logic [2:0] sag_phase_field, // Sag event phases
  input wire logic [2:0] high_current_phase_field, // Overcurrent phases
  input wire logic [2:0] high_voltage_phase_field, // Overvoltage phases
  input wire logic signed [23:0] summed_phase_current, // Phase current sum
  input wire logic signed [23:0] neutral_current_sample, // Neutral current
  input wire logic current_peak_done, // Current peak period end
  input wire logic voltage_peak_done, // Voltage peak period end
  input wire logic [31:0] config_checksum, // Checksum value
  input wire logic [1:0] power_state, // Power mode
  output logic second_interrupt_output_n // Interrupt, active low
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    mesf_pkg::mesf_state_t state;
    logic [7:0] settle_cnt;
    logic [31:0] flags;
    logic [31:0] mask;
    logic [8:0] idle_phase;
    logic [14:0] phase_event;
    logic [23:0] thresh;
    logic [31:0] cksum;
    logic cksum_valid;
    logic [1:0] pwr;
    logic ack;
    logic [31:0] rdata;
    logic irq_n;
  } mesf_top_st_t;

  mesf_top_st_t s_q;
  mesf_top_st_t s_d;

  logic order_err;
  logic neutral_over;
  logic [31:0] ev;
  logic [31:0] clr;
  logic [31:0] wmask;
  logic req;
  logic wr_done;
  logic soft_rst;
  logic wake;
  logic [31:0] rd_val;
  logic [31:0] be_bits;
  logic [31:0] thresh_new;
  logic hit_status;
  logic hit_mask;
  logic hit_ctrl;
  logic hit_thresh;
  logic in_run;
  logic settle_done;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Merge the enabled byte lanes of new data into an old value
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_val,
    input logic [31:0] lanes,
    input logic [31:0] new_val
  );
    lane_merge = (old_val & ~lanes) | (new_val & lanes);
  endfunction : lane_merge

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  mesf_order_chk u_order (
    .clk(clk),
    .sys_rst(sys_rst),
    .volt_rise(volt_rising_crossing),
    .order_err(order_err)
  );

  mesf_neutral_cmp u_neutral (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(HAS_NEUTRAL),
    .summed_phase_current(summed_phase_current),
    .neutral_current_sample(neutral_current_sample),
    .neutral_imbalance_threshold(s_q.thresh),
    .over(neutral_over)
  );

  // ----------------------------------------
  // Event vector
  // ----------------------------------------
  always_comb
  begin
    ev = 32'h0000_0000;
    ev[mesf_pkg::TOT_IDLE_BIT] = total_power_idle_flag; // [R01]
    ev[mesf_pkg::FUND_IDLE_BIT] = HAS_FUNDAMENTAL && fundamental_power_idle_flag; // [R02]
    ev[mesf_pkg::APP_IDLE_BIT] = apparent_power_idle_flag; // [R03]
    ev[mesf_pkg::VOLT_TIMEOUT_LSB +: 3] = volt_crossing_timeout; // [R04]
    ev[mesf_pkg::CURR_TIMEOUT_LSB +: 3] = curr_crossing_timeout; // [R05]
    ev[mesf_pkg::VOLT_SEEN_LSB +: 3] = volt_crossing_seen; // [R06]
    ev[mesf_pkg::CURR_SEEN_LSB +: 3] = curr_crossing_seen; // [R07]
    ev[mesf_pkg::SAG_BIT] = |sag_phase_field; // [R10]
    ev[mesf_pkg::HIGH_CURR_BIT] = |high_current_phase_field; // [R11]
    ev[mesf_pkg::HIGH_VOLT_BIT] = |high_voltage_phase_field; // [R12]
    ev[mesf_pkg::ORDER_ERR_BIT] = order_err; // [R13]
    ev[mesf_pkg::NEUTRAL_BIT] = neutral_over; // [R14]
    ev[mesf_pkg::CURR_PEAK_BIT] = current_peak_done; // [R16]
    ev[mesf_pkg::VOLT_PEAK_BIT] = voltage_peak_done; // [R17]
    ev[mesf_pkg::CKSUM_BIT] = s_q.cksum_valid && (config_checksum != s_q.cksum); // [R18]
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign req = avs_read || avs_write;
  assign wr_done = avs_write && s_q.ack;
  assign be_bits = mesf_pkg::be_mask(avs_byteenable);
  assign wmask = avs_writedata & be_bits;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign hit_status = (avs_address == mesf_pkg::STATUS_IDX);
  assign hit_mask = (avs_address == mesf_pkg::MASK_IDX);
  assign hit_ctrl = (avs_address == mesf_pkg::CTRL_IDX);
  assign hit_thresh = (avs_address == mesf_pkg::THRESH_IDX);
  assign in_run = (s_q.state == mesf_pkg::ST_RUN);
  // Threshold keeps only its three low lanes
  assign thresh_new = lane_merge({8'h00, s_q.thresh}, be_bits, avs_writedata);
  assign settle_done = (s_q.settle_cnt == mesf_pkg::SETTLE_LAST);

  always_comb
  begin
    case (avs_address)
      mesf_pkg::STATUS_IDX:
      begin
        rd_val = (s_q.flags & mesf_pkg::FLAG_MASK) | mesf_pkg::RSVD_ONE; // [R15]
      end
      mesf_pkg::MASK_IDX:
      begin
        rd_val = s_q.mask & mesf_pkg::FLAG_MASK;
      end
      mesf_pkg::CTRL_IDX:
      begin
        // Soft reset bit is a strobe and reads back 0
        rd_val = 32'h0000_0000;
      end
      mesf_pkg::IDLE_PH_IDX:
      begin
        rd_val = {23'h00_0000, s_q.idle_phase};
      end
      mesf_pkg::PH_EVT_IDX:
      begin
        rd_val = {17'h0_0000, s_q.phase_event};
      end
      mesf_pkg::THRESH_IDX:
      begin
        rd_val = {8'h00, s_q.thresh};
      end
      default:
      begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  // W1C clear mask for the status word
  always_comb
  begin
    clr = 32'h0000_0000;
    if (wr_done && hit_status && in_run)
    begin
      clr = wmask & mesf_pkg::FLAG_MASK; // [R19]
    end
  end

  assign soft_rst = wr_done && hit_ctrl && avs_byteenable[0]
    && avs_writedata[mesf_pkg::CTRL_SOFTWARE_RESET_COMMAND_BIT];
  assign wake = (s_q.pwr != mesf_pkg::PWR_NORMAL) && (power_state == mesf_pkg::PWR_NORMAL);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.ack = req && !s_q.ack;
    if (req && !s_q.ack)
    begin
      s_d.rdata = avs_read ? rd_val : s_q.rdata;
    end
    s_d.pwr = power_state;
    s_d.cksum = config_checksum;
    s_d.cksum_valid = 1'b1;

    case (s_q.state)
      mesf_pkg::ST_RUN:
      begin
        // Set wins over a clear in the same cycle
        s_d.flags = ((s_q.flags & ~clr) | ev) & mesf_pkg::FLAG_MASK; // [R19]
        s_d.flags = s_d.flags | mesf_pkg::RSVD_ONE; // [R15]
        if (total_power_idle_flag)
        begin
          s_d.idle_phase[mesf_pkg::TOT_PH_LSB +: 3] = total_idle_phase_field; // [R01]
        end
        if (HAS_FUNDAMENTAL && fundamental_power_idle_flag)
        begin
          s_d.idle_phase[mesf_pkg::FUND_PH_LSB +: 3] = fundamental_idle_phase_field; // [R02]
        end
        if (apparent_power_idle_flag)
        begin
          s_d.idle_phase[mesf_pkg::APP_PH_LSB +: 3] = apparent_idle_phase_field; // [R03]
        end
        if (|sag_phase_field)
        begin
          s_d.phase_event[mesf_pkg::SAG_PH_LSB +: 3] = sag_phase_field; // [R10]
        end
        if (|high_current_phase_field)
        begin
          s_d.phase_event[mesf_pkg::HIGH_CURR_PH_LSB +: 3] = high_current_phase_field; // [R11]
        end
        if (|high_voltage_phase_field)
        begin
          s_d.phase_event[mesf_pkg::HIGH_VOLT_PH_LSB +: 3] = high_voltage_phase_field; // [R12]
        end
        if (wr_done && hit_mask)
        begin
          s_d.mask = lane_merge(s_q.mask, be_bits, avs_writedata) & mesf_pkg::FLAG_MASK;
        end
        if (wr_done && hit_thresh)
        begin
          s_d.thresh = thresh_new[23:0];
        end
        if (soft_rst || wake)
        begin
          s_d.state = mesf_pkg::ST_SETTLE;
          s_d.settle_cnt = 8'h00;
        end
      end
      mesf_pkg::ST_SETTLE:
      begin
        // All registers return to defaults before completion is reported
        s_d.flags = mesf_pkg::RSVD_ONE;
        s_d.mask = mesf_pkg::MASK_RESET;
        s_d.thresh = mesf_pkg::THRESH_RESET;
        s_d.idle_phase = mesf_pkg::PHASE_RESET;
        s_d.phase_event = mesf_pkg::PH_EVT_RESET;
        s_d.settle_cnt = s_q.settle_cnt + 8'h01;
        if (settle_done)
        begin
          s_d.flags[mesf_pkg::RESET_DONE_BIT] = 1'b1; // [R08]
          s_d.state = mesf_pkg::ST_RUN;
        end
      end
      default:
      begin
        s_d.state = mesf_pkg::ST_RUN;
      end
    endcase

    // Enabled flags or unmaskable reset-complete pull the line low
    s_d.irq_n = !((|(s_d.flags & s_d.mask & mesf_pkg::FLAG_MASK)) // [R20]
      || s_d.flags[mesf_pkg::RESET_DONE_BIT]); // [R09]
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_q.state <= mesf_pkg::ST_RUN;
      s_q.settle_cnt <= 8'h00;
      s_q.flags <= mesf_pkg::STATUS_RESET; // [R08]
      s_q.mask <= mesf_pkg::MASK_RESET;
      s_q.idle_phase <= mesf_pkg::PHASE_RESET;
      s_q.phase_event <= mesf_pkg::PH_EVT_RESET;
      s_q.thresh <= mesf_pkg::THRESH_RESET;
      s_q.cksum <= 32'h0000_0000;
      s_q.cksum_valid <= 1'b0;
      s_q.pwr <= mesf_pkg::PWR_NORMAL;
      s_q.ack <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
      s_q.irq_n <= 1'b0; // [R09]
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = req && !s_q.ack;
  assign second_interrupt_output_n = s_q.irq_n;

endmodule : mesf_status_top

// file: testbench/mesf_status_properties.sv
// Port-level checks for the event status flag block
module mesf_status_properties (
  input wire logic clk, // Core clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic [15:0] avs_address, // Word index
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire logic [1:0] power_state, // Power mode
  input wire logic second_interrupt_output_n // Interrupt, active low
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Quiet window after writes and power changes
  // ----------------------------------------
  logic wr_done;
  logic [2:0] quiet_q;
  logic [2:0] quiet_d;

  assign wr_done = avs_write && !avs_waitrequest;

  always_comb
  begin
    quiet_d = (quiet_q != 3'h0) ? quiet_q - 3'h1 : 3'h0;
    if (wr_done || power_state != 2'h0)
      quiet_d = 3'h7;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      quiet_q <= 3'h0;
    else
      quiet_q <= quiet_d;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_RSVD_BITS:
    assert property (avs_read && !avs_waitrequest && avs_address == mesf_pkg::STATUS_IDX |->
      avs_readdata[21] && !avs_readdata[22] && avs_readdata[31:26] == 6'h00)
    else $error("reserved status bits wrong");
  AST_RESET_IRQ:
    assert property ($fell(sys_rst) |-> !second_interrupt_output_n)
    else $error("interrupt not low after reset");
  AST_PWR_SETTLE:
    assert property ($past(power_state) != 2'h0 && power_state == 2'h0 |->
      ##3 second_interrupt_output_n [*8] ##[20:45] !second_interrupt_output_n)
    else $error("return to normal power did not end in reset complete");
  AST_SOFTWARE_RESET_COMMAND_SETTLE:
    assert property (wr_done && avs_address == mesf_pkg::CTRL_IDX && avs_writedata[0] &&
      avs_byteenable[0] |->
      ##3 second_interrupt_output_n [*8] ##[20:45] !second_interrupt_output_n)
    else $error("soft reset did not end in reset complete");
  AST_IRQ_HOLD:
    assert property (!second_interrupt_output_n && quiet_q == 3'h0 && !wr_done &&
      power_state == 2'h0 |=> !second_interrupt_output_n)
    else $error("interrupt released without a host clear");
  AST_WAIT_ONE:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest longer than one cycle");
  AST_IDLE_READY:
    assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  AST_RDATA_HOLD:
    assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
endmodule : mesf_status_properties

bind mesf_status_top mesf_status_properties mesf_status_properties_inst (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .power_state(power_state),
  .second_interrupt_output_n(second_interrupt_output_n)
);

// file: testbench/meter_event_status_flags_tb.sv
// Self-checking testbench for the event status flag block
module meter_event_status_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] ST = mesf_pkg::STATUS_IDX;
  localparam logic [31:0] BASE = mesf_pkg::RSVD_ONE;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [25:0] evt = 26'h000_0000;
  logic [2:0] ph = 3'h0;
  logic [2:0] rise = 3'h0;
  logic signed [23:0] sum = 24'sh00_0000;
  logic signed [23:0] neu = 24'sh00_0000;
  logic [31:0] cks = 32'h0000_0000;
  logic [1:0] power_state = 2'h0;
  logic second_interrupt_output_n;
  int miscompares = 0;
  int n_tests = 0;
  logic [31:0] q;
  int b;

  always #12.5 clk = ~clk;

  mesf_status_top mesf_status_top_inst (
    .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest,
    .total_power_idle_flag(evt[0]), .total_idle_phase_field(ph),
    .fundamental_power_idle_flag(evt[1]), .fundamental_idle_phase_field(ph),
    .apparent_power_idle_flag(evt[2]), .apparent_idle_phase_field(ph),
    .volt_crossing_timeout(evt[5:3]), .curr_crossing_timeout(evt[8:6]),
    .volt_crossing_seen(evt[11:9]), .curr_crossing_seen(evt[14:12]),
    .volt_rising_crossing(rise), .sag_phase_field(evt[16] ? ph : 3'h0),
    .high_current_phase_field(evt[17] ? ph : 3'h0),
    .high_voltage_phase_field(evt[18] ? ph : 3'h0),
    .summed_phase_current(sum), .neutral_current_sample(neu),
    .current_peak_done(evt[23]), .voltage_peak_done(evt[24]), .config_checksum(cks),
    .power_state, .second_interrupt_output_n
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic results();
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50)
    begin
      miscompares++;
      results();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    check(nm, q, exp);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic pulse(input int k);
    @(posedge clk);
    evt <= 26'h1 << k;
    @(posedge clk);
    evt <= 26'h0;
  endtask : pulse

  task automatic rise_seq(input logic [2:0] v);
    @(posedge clk);
    rise <= v;
    @(posedge clk);
    rise <= 3'h0;
    repeat (3) @(posedge clk);
  endtask : rise_seq

  task automatic irq_is(input logic v, input string nm);
    repeat (3) @(negedge clk);
    check(nm, {31'h0, second_interrupt_output_n}, {31'h0, v});
  endtask : irq_is

  task automatic irq_wait();
    int n;
    n = 0;
    while (second_interrupt_output_n !== 1'b0 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 100)
    begin
      miscompares++;
      results();
    end
  endtask : irq_wait

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    irq_is(1'b0, "irq_reset");
    rd(ST, mesf_pkg::STATUS_RESET, "status_reset");
    wr(ST, 32'h0000_0000);
    rd(ST, mesf_pkg::STATUS_RESET, "status_w0");
    wr(ST, 32'hffff_ffff);
    rd(ST, BASE, "status_w1c");
    irq_is(1'b1, "irq_idle");
    rd(16'h0100, 32'h0000_0000, "unmapped");
    for (b = 0; b < 25; b++)
    begin
      if (b == 15 || (b > 18 && b < 23))
        continue;
      ph <= 3'(b % 7 + 1);
      pulse(b);
      rd(ST, BASE | (32'h1 << b), "flag_set");
      wr(ST, ~(32'h1 << b));
      rd(ST, BASE | (32'h1 << b), "flag_kept");
      wr(ST, 32'h1 << b);
      rd(ST, BASE, "flag_clear");
    end
    rd(mesf_pkg::IDLE_PH_IDX, 32'h0000_00d1, "idle_phase");
    rd(mesf_pkg::PH_EVT_IDX, 32'h0000_3a20, "event_phase");
    rise_seq(3'b001);
    rise_seq(3'b010);
    rise_seq(3'b100);
    rd(ST, BASE, "order_good");
    rise_seq(3'b001);
    rise_seq(3'b100);
    rd(ST, BASE | 32'h0008_0000, "order_bad");
    wr(ST, 32'h0008_0000);
    wr(mesf_pkg::THRESH_IDX, 32'h0000_0064);
    rd(mesf_pkg::THRESH_IDX, 32'h0000_0064, "threshold");
    sum <= 24'sh00_01f4;
    neu <= 24'sh00_012c;
    repeat (4) @(posedge clk);
    rd(ST, BASE | 32'h0010_0000, "neutral_over");
    sum <= 24'sh00_0190;
    repeat (4) @(posedge clk);
    wr(ST, 32'h0010_0000);
    repeat (4) @(posedge clk);
    rd(ST, BASE, "neutral_at_limit");
    sum <= 24'sh00_0000;
    neu <= 24'sh00_0000;
    cks <= 32'h1234_5678;
    repeat (3) @(posedge clk);
    rd(ST, BASE | 32'h0200_0000, "checksum");
    avs_byteenable <= 4'h7;
    wr(ST, 32'h0200_0000);
    rd(ST, BASE | 32'h0200_0000, "lane_kept");
    avs_byteenable <= 4'hf;
    wr(ST, 32'h0200_0000);
    wr(mesf_pkg::MASK_IDX, 32'h0000_0001);
    pulse(3);
    irq_is(1'b1, "irq_masked");
    pulse(0);
    irq_is(1'b0, "irq_enabled");
    wr(ST, 32'h0000_0009);
    irq_is(1'b1, "irq_cleared");
    @(posedge clk);
    power_state <= 2'h2;
    repeat (5) @(posedge clk);
    power_state <= 2'h0;
    repeat (4) @(posedge clk);
    irq_wait();
    rd(ST, mesf_pkg::STATUS_RESET, "power_return");
    rd(mesf_pkg::MASK_IDX, 32'h0000_0000, "mask_default");
    wr(ST, 32'h0000_8000);
    irq_is(1'b1, "irq_done_clear");
    wr(mesf_pkg::CTRL_IDX, 32'h0000_0001);
    repeat (4) @(posedge clk);
    irq_wait();
    rd(ST, mesf_pkg::STATUS_RESET, "soft_reset");
    results();
  end
endmodule : meter_event_status_flags_tb
